/* File: design/vcc_out_stage.sv */
// Purpose : solenoid output stage for one demand pair
// Assumes : unsigned current demands, one clock
// Notes   : registered outputs
`timescale 1ns/10ps
module vcc_out_stage #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // settings and window state
  input  wire logic         inv_a,
  input  wire logic         inv_b,
  input  wire logic         swap,
  input  wire logic         inpos_on,
  input  wire logic         imin_en,
  input  wire logic [W-1:0] imin,
  input  wire logic         in_off_win,
  // demands in, solenoid drives out
  input  wire logic [W-1:0] dem_a,
  input  wire logic [W-1:0] dem_b,
  output logic      [W-1:0] sol_a,
  output logic      [W-1:0] sol_b
);
  logic [W-1:0] a_nxt, b_nxt, ra, rb;
  // ==========================================================
  // route, invert, floor, window-off
  always_comb begin
    ra = swap ? dem_b : dem_a; // RULE5
    rb = swap ? dem_a : dem_b; // RULE5
    a_nxt = inv_a ? ~ra : ra; // RULE3
    b_nxt = inv_b ? ~rb : rb; // RULE4
    // floor after inversion, so an inverted drive never dips below the minimum
    if (imin_en && a_nxt < imin) a_nxt = imin; // RULE8
    if (imin_en && b_nxt < imin) b_nxt = imin; // RULE8
    if (in_off_win && !inpos_on) begin // RULE6 RULE7
      a_nxt = '0;
      b_nxt = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sol_a <= '0;
      sol_b <= '0;
    end else begin
      sol_a <= a_nxt;
      sol_b <= b_nxt;
    end
  end
endmodule

/* File: design/vcc_pkg.sv */
// Purpose : constants for the valve controller configuration block
// Assumes : axi4-lite slave, 32-bit data, word-aligned registers
// Notes   : register offsets are byte addresses
package vcc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] VCC_OFS_MODE    = 8'h00;
  localparam logic [7:0] VCC_OFS_CFG     = 8'h04;
  localparam logic [7:0] VCC_OFS_OPMODE  = 8'h08;
  localparam logic [7:0] VCC_OFS_SCALE   = 8'h0c;
  localparam logic [7:0] VCC_OFS_IMIN    = 8'h10;
  localparam logic [7:0] VCC_OFS_STATUS  = 8'h14;
  // ==========================================================
  // controller mode codes (signed 8 bit)
  localparam logic [7:0] VCC_CM_VALVE_OL  = 8'h03;
  localparam logic [7:0] VCC_CM_VALVE_CL  = 8'h04;
  localparam logic [7:0] VCC_CM_POS_OL    = 8'h06;
  localparam logic [7:0] VCC_CM_SPEED     = 8'h07;
  localparam logic [7:0] VCC_CM_POS_CL    = 8'h09;
  localparam logic [7:0] VCC_CM_PRESS     = 8'hfb;
  localparam logic [7:0] VCC_CM_PQ        = 8'hf7;
  localparam logic [7:0] VCC_CM_ALT       = 8'hf6;
  localparam logic [7:0] VCC_RST_MODE     = VCC_CM_VALVE_OL;
  // ==========================================================
  // cfg field positions
  localparam int VCC_B_INV_A   = 0;
  localparam int VCC_B_INV_B   = 1;
  localparam int VCC_B_SWAP    = 2;
  localparam int VCC_B_INPOS   = 3;
  localparam int VCC_B_IMIN_P  = 4;
  localparam int VCC_B_IMIN_Q  = 5;
  localparam logic [5:0] VCC_RST_CFG = 6'h00;
  // status field positions
  localparam int VCC_B_ST_DIS  = 0;
  localparam int VCC_B_ST_REJ  = 1;
  localparam int VCC_B_ST_OPEFF = 2;
  // ==========================================================
  // operating modes and signal types
  typedef enum logic [1:0] {
    VCC_OP_UNI1 = 2'h0,
    VCC_OP_UNI2 = 2'h1,
    VCC_OP_BIP2 = 2'h2,
    VCC_OP_UNIDI = 2'h3
  } vcc_opmode_t;
  localparam logic [1:0] VCC_SIG_UNI = 2'h0;
  localparam logic [1:0] VCC_SIG_BIP = 2'h1;
  localparam logic [15:0] VCC_RST_IMIN  = 16'h0000;
  localparam logic [15:0] VCC_RST_SCALE = 16'h0000;
  localparam logic [1:0]  VCC_AXI_OKAY   = 2'h0;
  localparam logic [1:0]  VCC_AXI_SLVERR = 2'h2;
endpackage

/* File: design/vcc_top.sv */
// Function
// [RULE1] mode is signed code of eight values
// [RULE2] mode change adjusts dependent settings automatically
// [RULE3] inversion A unavailable in modes 6, 9
// [RULE4] inversion B unavailable in modes 6, 9
// [RULE5] control sense inverted swaps solenoid demands
// [RULE6] in-position off: outputs off inside window
// [RULE7] in-position on: outputs kept inside window
// [RULE8] minimum current floor, separate position/pressure enables
// [RULE9] opmode and scaling writable only when disabled
// [RULE10] opmode honoured only in four controller modes
// [RULE11] operating mode takes four values
// [RULE12] opmode change adapts command signal type
//
// Purpose : configuration registers and mode checks of a valve controller
// Assumes : axi4-lite master, one transfer at a time each direction
// Notes   : illegal writes are dropped (cfg still takes the other fields) and flagged, answered OKAY
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module vcc_top #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // axi4-lite write
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // axi4-lite read
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [7:0]   s_axi_araddr,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // device state and controller
  input  wire logic         dev_disabled,
  input  wire logic         in_off_win,
  input  wire logic         press_active,
  input  wire logic [W-1:0] dem_a,
  input  wire logic [W-1:0] dem_b,
  // outputs
  output logic [W-1:0]      sol_a,
  output logic [W-1:0]      sol_b,
  output logic [1:0]        op_mode_eff,
  output logic              op_mode_valid,
  output logic [1:0]        cmd_sig_type
);
  import vcc_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic mode_legal(input logic [7:0] m);
    case (m) // RULE1
      VCC_CM_VALVE_OL, VCC_CM_VALVE_CL, VCC_CM_POS_OL, VCC_CM_SPEED,
      VCC_CM_POS_CL, VCC_CM_PRESS, VCC_CM_PQ, VCC_CM_ALT: mode_legal = 1'b1;
      default: mode_legal = 1'b0;
    endcase
  endfunction
  function automatic logic inv_allowed(input logic [7:0] m);
    inv_allowed = !(m == VCC_CM_POS_OL || m == VCC_CM_POS_CL); // RULE3 RULE4
  endfunction
  function automatic logic op_used(input logic [7:0] m);
    op_used = (m == VCC_CM_VALVE_OL) || (m == VCC_CM_POS_OL) || // RULE10
              (m == VCC_CM_SPEED) || (m == VCC_CM_PQ);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  // ==========================================================
  // registers
  logic [7:0]   mode_r, mode_nxt;
  logic [5:0]   cfg_r, cfg_nxt;
  logic [1:0]   op_r, op_nxt;
  logic [1:0]   sig_r, sig_nxt;
  logic [15:0]  scale_r, scale_nxt;
  logic [W-1:0] imin_r, imin_nxt;
  logic         rej_r, rej_nxt;
  logic         aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]   awa_r, awa_nxt;
  logic [31:0]  wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]   ws_r, ws_nxt;
  logic [1:0]   br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0]  nw;
  logic [7:0]   nm;
  logic         do_wr;

  assign s_axi_awready = !aw_r && !bv_r;
  assign s_axi_wready  = !w_r && !bv_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;

  // ==========================================================
  // write channel capture and register update
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    mode_nxt = mode_r;
    cfg_nxt = cfg_r;
    op_nxt = op_r;
    sig_nxt = sig_r;
    scale_nxt = scale_r;
    imin_nxt = imin_r;
    rej_nxt = rej_r;
    nw = '0;
    nm = mode_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    // both halves held: the write lands and the answer rises together at the next edge;
    // a refused value leaves its register alone (cfg still takes its other fields) and only raises the reject flag
    do_wr = aw_r && w_r && !bv_r;
    if (do_wr) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = VCC_AXI_OKAY;
      case (awa_r)
        VCC_OFS_MODE: begin
          nw = merge({24'h000000, mode_r}, wd_r, ws_r);
          nm = nw[7:0];
          if (mode_legal(nm)) begin
            mode_nxt = nm;
            if (!inv_allowed(nm)) begin // RULE2 RULE3 RULE4
              cfg_nxt[VCC_B_INV_A] = 1'b0;
              cfg_nxt[VCC_B_INV_B] = 1'b0;
            end
          end else rej_nxt = 1'b1;
        end
        VCC_OFS_CFG: begin
          nw = merge({26'h0000000, cfg_r}, wd_r, ws_r);
          cfg_nxt = nw[5:0];
          if (!inv_allowed(mode_r)) begin // RULE3 RULE4
            cfg_nxt[VCC_B_INV_A] = 1'b0;
            cfg_nxt[VCC_B_INV_B] = 1'b0;
            if (nw[VCC_B_INV_A] || nw[VCC_B_INV_B]) rej_nxt = 1'b1;
          end
        end
        VCC_OFS_OPMODE: begin
          nw = merge({30'h00000000, op_r}, wd_r, ws_r);
          if (dev_disabled) begin // RULE9
            op_nxt = nw[1:0]; // RULE11
            if (nw[1:0] != op_r) // RULE12
              sig_nxt = (nw[1:0] == VCC_OP_BIP2) ? VCC_SIG_BIP : VCC_SIG_UNI;
          end else rej_nxt = 1'b1; // RULE9
        end
        VCC_OFS_SCALE: begin
          nw = merge({16'h0000, scale_r}, wd_r, ws_r);
          if (dev_disabled) scale_nxt = nw[15:0]; // RULE9
          else rej_nxt = 1'b1;
        end
        VCC_OFS_IMIN: begin
          nw = merge({{(32-W){1'b0}}, imin_r}, wd_r, ws_r);
          imin_nxt = nw[W-1:0];
        end
        VCC_OFS_STATUS: begin
          if (ws_r[0] && wd_r[VCC_B_ST_REJ]) rej_nxt = 1'b0;
        end
        default: br_nxt = VCC_AXI_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // read channel
  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (rv_r && s_axi_rready) rv_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = VCC_AXI_OKAY;
      case (s_axi_araddr)
        VCC_OFS_MODE:   rd_nxt = {24'h000000, mode_r};
        VCC_OFS_CFG:    rd_nxt = {26'h0000000, cfg_r};
        VCC_OFS_OPMODE: rd_nxt = {28'h0000000, sig_r, op_r};
        VCC_OFS_SCALE:  rd_nxt = {16'h0000, scale_r};
        VCC_OFS_IMIN:   rd_nxt = {{(32-W){1'b0}}, imin_r};
        VCC_OFS_STATUS: rd_nxt = {29'h00000000, op_used(mode_r), rej_r, dev_disabled};
        default: begin
          rd_nxt = 32'h00000000;
          rr_nxt = VCC_AXI_SLVERR;
        end
      endcase
    end
  end

  // register all configuration and bus state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_r <= VCC_RST_MODE;
      cfg_r <= VCC_RST_CFG;
      op_r <= VCC_OP_UNI1;
      sig_r <= VCC_SIG_UNI;
      scale_r <= VCC_RST_SCALE;
      imin_r <= W'(VCC_RST_IMIN);
      rej_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      br_r <= VCC_AXI_OKAY;
      rd_r <= 32'h00000000;
      rr_r <= VCC_AXI_OKAY;
    end else begin
      mode_r <= mode_nxt;
      cfg_r <= cfg_nxt;
      op_r <= op_nxt;
      sig_r <= sig_nxt;
      scale_r <= scale_nxt;
      imin_r <= imin_nxt;
      rej_r <= rej_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      br_r <= br_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
    end
  end

  // ==========================================================
  // effective operating mode and floor selection
  logic       imin_sel;
  logic [1:0] eff_nxt;
  logic       valid_nxt;
  // operating mode only counts in the four modes that use it
  always_comb begin
    valid_nxt = op_used(mode_r); // RULE10
    eff_nxt = valid_nxt ? op_r : 2'h0; // RULE10
  end
  // floor enable: alternating mode follows the active controller
  always_comb begin
    if (mode_r == VCC_CM_ALT)
      imin_sel = press_active ? cfg_r[VCC_B_IMIN_Q] : cfg_r[VCC_B_IMIN_P]; // RULE8
    else if (mode_r == VCC_CM_PRESS || mode_r == VCC_CM_PQ)
      imin_sel = cfg_r[VCC_B_IMIN_Q]; // RULE8
    else
      imin_sel = cfg_r[VCC_B_IMIN_P]; // RULE8
  end
  // register the mode outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_mode_eff <= 2'h0;
      op_mode_valid <= 1'b0;
      cmd_sig_type <= VCC_SIG_UNI;
    end else begin
      op_mode_eff <= eff_nxt;
      op_mode_valid <= valid_nxt;
      cmd_sig_type <= sig_r; // RULE12
    end
  end

  // solenoid output stage
  vcc_out_stage #(.W(W)) u_out (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .inv_a      (cfg_r[VCC_B_INV_A]),
    .inv_b      (cfg_r[VCC_B_INV_B]),
    .swap       (cfg_r[VCC_B_SWAP]),
    .inpos_on   (cfg_r[VCC_B_INPOS]),
    .imin_en    (imin_sel),
    .imin       (imin_r),
    .in_off_win (in_off_win),
    .dem_a      (dem_a),
    .dem_b      (dem_b),
    .sol_a      (sol_a),
    .sol_b      (sol_b)
  );
endmodule

/* File: test/tb_valve_controller_config_modes.sv */
// Purpose : self-checking bench of the configuration block
// Assumes : register bus driven at rising edges, one transfer at a time
// Notes   : expected results queued by drivers, compared by watchers
`timescale 1ns/10ps
module tb_valve_controller_config_modes;
  import vcc_pkg::*;
  logic clk_sys = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, dev_disabled = 1, in_off_win = 0;
  logic press_active = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, op_mode_valid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mode_r, codes [8];
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_mode_eff, cmd_sig_type, op_r, sig_r;
  logic [15:0] dem_a, dem_b, sol_a, sol_b, imin_r;
  logic [5:0] cfg_r;
  logic [65:0] rq [$];
  logic [36:0] sq [$];
  logic [1:0] bq [$];
  integer seed = 94181, err_count = 0, checks_done = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  vcc_top vcc_top_i (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dev_disabled, .in_off_win,
    .press_active, .dem_a, .dem_b, .sol_a, .sol_b, .op_mode_eff, .op_mode_valid,
    .cmd_sig_type);
  vcc_dem_model vcc_dem_model_i (.clk_sys, .reset, .dem_a, .dem_b);
  // ==========================================================
  // checking
  task automatic chk(input logic [36:0] g, input logic [36:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] msk(input logic [7:0] a);
    return a == VCC_OFS_MODE ? 32'hff : a == VCC_OFS_CFG ? 32'h3f : a == VCC_OFS_OPMODE ?
      32'hf : a == VCC_OFS_STATUS ? 32'h7 : a > VCC_OFS_STATUS ? 32'hffffffff : 32'hffff;
  endfunction
  function automatic logic used(input logic [7:0] m);
    return m == VCC_CM_VALVE_OL || m == VCC_CM_POS_OL || m == VCC_CM_SPEED || m == VCC_CM_PQ;
  endfunction
  // solenoid drive expected from the settings and the present demands
  function automatic logic [31:0] sol_exp();
    logic [15:0] x, y;
    logic en;
    x = cfg_r[2] ? dem_b : dem_a;
    y = cfg_r[2] ? dem_a : dem_b;
    en = mode_r == VCC_CM_ALT ? cfg_r[press_active ? 5 : 4] :
      (mode_r == VCC_CM_PRESS || mode_r == VCC_CM_PQ) ? cfg_r[5] : cfg_r[4];
    if (cfg_r[0]) x = ~x;
    if (cfg_r[1]) y = ~y;
    if (en && x < imin_r) x = imin_r;
    if (en && y < imin_r) y = imin_r;
    if (in_off_win && !cfg_r[3]) return 32'h0;
    return {x, y};
  endfunction
  // watchers take the oldest note as each result appears
  always @(posedge clk_sys) begin
    logic [65:0] e;
    cyc++;
    if (s_axi_bvalid && s_axi_bready) chk(37'(s_axi_bresp), 37'(bq.pop_front()));
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk(37'({s_axi_rresp, s_axi_rdata & e[65:34]}), 37'(e[33:0]));
    end
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  always @(negedge clk_sys)
    if (sq.size() > 0) chk({op_mode_valid, op_mode_eff, cmd_sig_type, sol_a, sol_b}, sq.pop_front());
  // ==========================================================
  // bus master tasks
  // ready is at times raised only once the answer shows, so answers must wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic late;
    late = 1'($random(seed));
    @(posedge clk_sys);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic late;
    late = 1'($random(seed));
    @(posedge clk_sys);
    rq.push_back({msk(a), r, d & msk(a)});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !late;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    codes = '{VCC_CM_VALVE_OL, VCC_CM_VALVE_CL, VCC_CM_POS_OL, VCC_CM_SPEED, VCC_CM_POS_CL,
      VCC_CM_PRESS, VCC_CM_PQ, VCC_CM_ALT};
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(VCC_OFS_MODE, 32'(VCC_RST_MODE), VCC_AXI_OKAY);
    for (int a = 4; a < 20; a += 4) rd(8'(a), 32'h0, VCC_AXI_OKAY);
    rd(8'h18, 32'h0, VCC_AXI_SLVERR);
    wr(8'h18, 32'h1, VCC_AXI_SLVERR);
    $display("test reset done");
    foreach (codes[i]) begin
      wr(VCC_OFS_MODE, 32'(codes[i]), VCC_AXI_OKAY);
      rd(VCC_OFS_MODE, 32'(codes[i]), VCC_AXI_OKAY);
    end
    wr(VCC_OFS_MODE, 32'h5, VCC_AXI_OKAY);
    rd(VCC_OFS_MODE, 32'(VCC_CM_ALT), VCC_AXI_OKAY);
    rd(VCC_OFS_STATUS, 32'h3, VCC_AXI_OKAY);
    wr(VCC_OFS_STATUS, 32'h2, VCC_AXI_OKAY);
    $display("test codes done");
    for (int i = 0; i < 2; i++) begin
      wr(VCC_OFS_MODE, 32'(VCC_CM_VALVE_OL), VCC_AXI_OKAY);
      wr(VCC_OFS_CFG, 32'h3, VCC_AXI_OKAY);
      rd(VCC_OFS_CFG, 32'h3, VCC_AXI_OKAY);
      wr(VCC_OFS_MODE, 32'(i ? VCC_CM_POS_CL : VCC_CM_POS_OL), VCC_AXI_OKAY);
      rd(VCC_OFS_CFG, 32'h0, VCC_AXI_OKAY);
      wr(VCC_OFS_CFG, 32'(i + 1), VCC_AXI_OKAY);
      rd(VCC_OFS_CFG, 32'h0, VCC_AXI_OKAY);
      rd(VCC_OFS_STATUS, i ? 32'h3 : 32'h7, VCC_AXI_OKAY);
      wr(VCC_OFS_STATUS, 32'h2, VCC_AXI_OKAY);
    end
    $display("test inversion done");
    wr(VCC_OFS_MODE, 32'(VCC_CM_VALVE_OL), VCC_AXI_OKAY);
    dev_disabled <= 1'b0;
    wr(VCC_OFS_OPMODE, 32'h2, VCC_AXI_OKAY);
    wr(VCC_OFS_SCALE, 32'h1234, VCC_AXI_OKAY);
    rd(VCC_OFS_OPMODE, 32'h0, VCC_AXI_OKAY);
    rd(VCC_OFS_SCALE, 32'h0, VCC_AXI_OKAY);
    rd(VCC_OFS_STATUS, 32'h6, VCC_AXI_OKAY);
    wr(VCC_OFS_STATUS, 32'h2, VCC_AXI_OKAY);
    dev_disabled <= 1'b1;
    for (int o = 0; o < 5; o++) begin
      wr(VCC_OFS_OPMODE, 32'(o % 4 ^ (o / 4) * 2), VCC_AXI_OKAY);
      rd(VCC_OFS_OPMODE, (o == 2 || o == 4) ? 32'h6 : 32'(o % 4), VCC_AXI_OKAY);
    end
    wr(VCC_OFS_SCALE, 32'h1234, VCC_AXI_OKAY);
    rd(VCC_OFS_SCALE, 32'h1234, VCC_AXI_OKAY);
    {op_r, sig_r} = {2'h2, VCC_SIG_BIP};
    $display("test opmode done");
    foreach (codes[i]) begin
      mode_r = codes[i];
      cfg_r = 6'($random(seed)) & (mode_r == VCC_CM_POS_OL || mode_r == VCC_CM_POS_CL ? 6'h3c : 6'h3f);
      imin_r = 16'($random(seed));
      wr(VCC_OFS_MODE, 32'(mode_r), VCC_AXI_OKAY);
      wr(VCC_OFS_CFG, 32'(cfg_r), VCC_AXI_OKAY);
      wr(VCC_OFS_IMIN, 32'(imin_r), VCC_AXI_OKAY);
      repeat (12) begin
        in_off_win <= 1'($random(seed));
        press_active <= 1'($random(seed));
        @(posedge clk_sys);
        sq.push_back({used(mode_r), used(mode_r) ? op_r : 2'h0, sig_r, sol_exp()});
      end
    end
    $display("test solenoid done");
    repeat (3) @(posedge clk_sys);
    results();
  end
endmodule
bind vcc_top vcc_checker vcc_checker_i (.clk_sys(clk_sys), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .op_mode_eff(op_mode_eff), .op_mode_valid(op_mode_valid), .cmd_sig_type(cmd_sig_type));

/* File: test/vcc_dem_model.sv */
// Purpose : controller demand source facing the configuration block
// Assumes : demands change every cycle over the full range
// Notes   : zero while in reset
`timescale 1ns/10ps
module vcc_dem_model #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // demands for solenoids a and b
  output logic      [W-1:0] dem_a,
  output logic      [W-1:0] dem_b
);
  integer seed_m = 94181;
  // fresh demand pair each cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      dem_a <= '0;
      dem_b <= '0;
    end else begin
      dem_a <= W'($random(seed_m));
      dem_b <= W'($random(seed_m));
    end
  end
endmodule

/* File: test/vcc_top_asserts.sv */
// Purpose : port-level checks of the valve controller configuration block
// Assumes : one clock, synchronous active-high reset
// Notes   : bound to vcc_top from the testbench top file
`timescale 1ns/10ps
module vcc_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // operating mode outputs
  input wire logic [1:0]  op_mode_eff,
  input wire logic        op_mode_valid,
  input wire logic [1:0]  cmd_sig_type
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // bus handshakes
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response latency wrong");
  a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response latency wrong");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // ==========================================================
  // operating mode
  a_eff_zero: assert property (!op_mode_valid |-> op_mode_eff == 2'h0)
    else $error("unused operating mode not zero");
  a_bip_sig: assert property (op_mode_valid && op_mode_eff == 2'h2 |-> cmd_sig_type == 2'h1)
    else $error("bipolar mode without bipolar signal");
endmodule
